//--- core/spiwp_defines.svh
// Purpose: constants of the write-protect command logic
// Assumes: 250 MHz system clock
// Notes:   opcodes, status bit positions, reset values, write time
`ifndef SPIWP_DEFINES_SVH
`define SPIWP_DEFINES_SVH

`define SPIWP_OP_REG_WRITE    8'h01
`define SPIWP_OP_WRITE_UNLOCK 8'h06
`define SPIWP_OP_WRITE_LOCK   8'h04
`define SPIWP_OP_CLEAR_FLAGS  8'h30
`define SPIWP_OP_BANK_ACCESS  8'hB9

`define SPIWP_LEN_CMD         5'h08
`define SPIWP_LEN_ONE_BYTE    5'h10
`define SPIWP_LEN_TWO_BYTES   5'h18
`define SPIWP_CNT_MAX         5'h1F

`define SPIWP_SR_BUSY         0
`define SPIWP_SR_LATCH        1
`define SPIWP_SR_LEVEL_LO     2
`define SPIWP_SR_LEVEL_HI     4
`define SPIWP_SR_ERASE_FAIL   5
`define SPIWP_SR_PROG_FAIL    6
`define SPIWP_SR_LOCK         7
`define SPIWP_CFG_QUAD        1

`define SPIWP_STATUS_RESET    8'h00
`define SPIWP_CFG_RESET       8'h00

`define SPIWP_CLK_MHZ         250
`define SPIWP_WRITE_TIME_NS   1000
`define SPIWP_WRITE_CYCLES \
	((`SPIWP_WRITE_TIME_NS * `SPIWP_CLK_MHZ + 999) / 1000)

`endif

//--- core/spiwp_pkg.sv
// Purpose: types of the write-protect command logic
// Assumes: nothing
// Notes:   all state of the controller lives in one packed struct
package spiwp_pkg;

	typedef enum logic [0:0] {
		PH_IDLE  = 1'b0,
		PH_WRITE = 1'b1
	} spiwp_phase_t;

	typedef struct packed {
		logic         sck_last;
		logic         cs_n_last;
		logic [4:0]   bit_cnt;
		logic [7:0]   opcode;
		logic [15:0]  data;
		spiwp_phase_t phase;
		logic [15:0]  timer;
		logic [7:0]   pend_status;
		logic [7:0]   pend_cfg;
		logic         pend_cfg_en;
		logic [2:0]   protect_level;
		logic         status_lock;
		logic         write_latch;
		logic         erase_fail;
		logic         program_fail;
		logic [7:0]   cfg;
		logic [1:0]   bank;
		logic         bank_armed;
	} spiwp_state_t;

endpackage

//--- core/spiwp_ctrl.sv
// Purpose: register-write, write latch and flag clear command logic
// Assumes: SPI mode 0, all pins synchronous to clk, sck far below clk
// Notes:   the self-timed register write lasts a fixed cycle count
`include "spiwp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module spiwp_ctrl #(
	parameter int WRITE_CYCLES = `SPIWP_WRITE_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic       si,
	input  wire logic       write_protect_n,
	input  wire logic       embedded_busy,
	input  wire logic       erase_fail_set,
	input  wire logic       program_fail_set,
	output logic [7:0]      status_reg_one,
	output logic [7:0]      config_reg,
	output logic [1:0]      bank_addr_reg,
	output logic            write_latch,
	output logic            op_in_progress,
	output logic            hw_protected,
	output logic            array_write_allow
);

	spiwp_pkg::spiwp_state_t state_reg;
	spiwp_pkg::spiwp_state_t state_next;

	logic sck_rise;
	logic frame_end;
	logic busy;
	logic hw_locked;
	logic unlock_go;
	logic lock_go;
	logic lock_busy;
	logic clear_go;
	logic bank_go;
	logic len_ok;
	logic reg_go;
	logic write_done;

	function automatic logic cmd_is(
		input logic [7:0] op,
		input logic [4:0] cnt,
		input logic [7:0] code,
		input logic [4:0] len
	);
		cmd_is = (op == code) && (cnt == len);
	endfunction

	assign sck_rise  = sck & ~state_reg.sck_last;
	assign frame_end = cs_n & ~state_reg.cs_n_last;
	assign busy      = (state_reg.phase == spiwp_pkg::PH_WRITE) |
		embedded_busy | state_reg.erase_fail | state_reg.program_fail;
	// pin protection only while the pin is not an io line
	assign hw_locked = state_reg.status_lock & ~write_protect_n &
		~state_reg.cfg[`SPIWP_CFG_QUAD];
	assign unlock_go = frame_end & cmd_is(state_reg.opcode,
		state_reg.bit_cnt, `SPIWP_OP_WRITE_UNLOCK,
		`SPIWP_LEN_CMD);
	assign lock_busy = frame_end & cmd_is(state_reg.opcode,
		state_reg.bit_cnt, `SPIWP_OP_WRITE_LOCK, `SPIWP_LEN_CMD);
	assign lock_go   = lock_busy & ~busy;
	assign clear_go  = frame_end & cmd_is(state_reg.opcode,
		state_reg.bit_cnt, `SPIWP_OP_CLEAR_FLAGS,
		`SPIWP_LEN_CMD);
	assign len_ok    = (state_reg.opcode == `SPIWP_OP_REG_WRITE) &&
		((state_reg.bit_cnt == `SPIWP_LEN_ONE_BYTE) ||
		(state_reg.bit_cnt == `SPIWP_LEN_TWO_BYTES));
	assign bank_go   = frame_end & state_reg.bank_armed & len_ok &
		~busy;
	// quad mode allows only the two-byte form
	assign reg_go    = frame_end & ~state_reg.bank_armed & len_ok &
		state_reg.write_latch & ~hw_locked & ~busy &
		(~state_reg.cfg[`SPIWP_CFG_QUAD] |
		(state_reg.bit_cnt == `SPIWP_LEN_TWO_BYTES));
	assign write_done = (state_reg.phase == spiwp_pkg::PH_WRITE) &&
		(state_reg.timer == 16'h0000);

	always_comb begin
		state_next = state_reg;
		state_next.sck_last  = sck;
		state_next.cs_n_last = cs_n;
		if (~cs_n & state_reg.cs_n_last) begin
			state_next.bit_cnt = 5'h00;
		end else if (~cs_n && sck_rise) begin
			if (state_reg.bit_cnt != `SPIWP_CNT_MAX) begin
				state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
			end
			if (state_reg.bit_cnt < `SPIWP_LEN_CMD) begin
				state_next.opcode = {state_reg.opcode[6:0], si};
			end else if (state_reg.bit_cnt < `SPIWP_LEN_TWO_BYTES) begin
				state_next.data = {state_reg.data[14:0], si};
			end
		end
		// any finished frame other than the bank access command closes bank access
		if (frame_end) begin
			state_next.bank_armed = cmd_is(state_reg.opcode,
				state_reg.bit_cnt, `SPIWP_OP_BANK_ACCESS,
				`SPIWP_LEN_CMD);
		end
		if (bank_go) begin
			if (state_reg.bit_cnt == `SPIWP_LEN_ONE_BYTE) begin
				state_next.bank = state_reg.data[1:0];
			end else begin
				state_next.bank = state_reg.data[9:8];
			end
		end
		if (reg_go) begin
			state_next.phase = spiwp_pkg::PH_WRITE;
			state_next.timer = 16'(WRITE_CYCLES - 1);
			if (state_reg.bit_cnt == `SPIWP_LEN_ONE_BYTE) begin
				state_next.pend_status = state_reg.data[7:0];
				state_next.pend_cfg_en = 1'b0;
			end else begin
				state_next.pend_status = state_reg.data[15:8];
				state_next.pend_cfg    = state_reg.data[7:0];
				state_next.pend_cfg_en = 1'b1;
			end
		end else if (state_reg.phase == spiwp_pkg::PH_WRITE) begin
			if (write_done) begin
				state_next.phase = spiwp_pkg::PH_IDLE;
				state_next.protect_level = state_reg.pend_status[
					`SPIWP_SR_LEVEL_HI:`SPIWP_SR_LEVEL_LO];
				state_next.status_lock =
					state_reg.pend_status[`SPIWP_SR_LOCK];
				if (state_reg.pend_cfg_en) begin
					state_next.cfg = state_reg.pend_cfg;
				end
			end else begin
				state_next.timer = state_reg.timer - 16'h0001;
			end
		end
		// unlock wins over a clear in the same cycle
		if (unlock_go) begin
			state_next.write_latch = 1'b1;
		end else if (lock_go || write_done) begin
			state_next.write_latch = 1'b0;
		end
		// a fail event wins over the flag clear
		if (erase_fail_set) begin
			state_next.erase_fail = 1'b1;
		end else if (clear_go) begin
			state_next.erase_fail = 1'b0;
		end
		if (program_fail_set) begin
			state_next.program_fail = 1'b1;
		end else if (clear_go) begin
			state_next.program_fail = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.sck_last <= 1'b0;
			state_reg.cs_n_last <= 1'b1;
			state_reg.cfg <= `SPIWP_CFG_RESET;
			{state_reg.status_lock, state_reg.program_fail,
				state_reg.erase_fail, state_reg.protect_level,
				state_reg.write_latch} <=
				7'(`SPIWP_STATUS_RESET >> 1);
		end else begin
			state_reg <= state_next;
		end
	end

	assign op_in_progress    = busy;
	assign write_latch       = state_reg.write_latch;
	assign hw_protected      = hw_locked;
	assign array_write_allow = state_reg.write_latch;
	assign config_reg        = state_reg.cfg;
	assign bank_addr_reg     = state_reg.bank;
	assign status_reg_one    = {state_reg.status_lock,
		state_reg.program_fail, state_reg.erase_fail,
		state_reg.protect_level, state_reg.write_latch, busy};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_unlock_sets;
		unlock_go |=> write_latch;
	endproperty
	a_unlock_sets: assert property (p_unlock_sets)
		else $error("unlock did not set write latch");

	property p_lock_busy_ignored;
		lock_busy && busy && !write_done |=> $stable(write_latch);
	endproperty
	a_lock_busy_ignored: assert property (p_lock_busy_ignored)
		else $error("lock changed latch while busy");

	property p_lock_clears;
		lock_go |=> !write_latch;
	endproperty
	a_lock_clears: assert property (p_lock_clears)
		else $error("lock did not clear write latch");

	property p_clear_flags;
		clear_go && !erase_fail_set && !program_fail_set
			|=> !status_reg_one[5] && !status_reg_one[6];
	endproperty
	a_clear_flags: assert property (p_clear_flags)
		else $error("fail flags not cleared");

	property p_clear_keeps_latch;
		clear_go && !write_done |=> $stable(write_latch);
	endproperty
	a_clear_keeps_latch: assert property (p_clear_keeps_latch)
		else $error("flag clear changed write latch");

	property p_locked_rejects;
		frame_end && hw_locked && !busy
			|=> state_reg.phase == spiwp_pkg::PH_IDLE
			##1 $stable(config_reg) && $stable(status_reg_one[7]) &&
			$stable(status_reg_one[4:2]);
	endproperty
	a_locked_rejects: assert property (p_locked_rejects)
		else $error("protected registers were written");

	property p_no_latch_no_write;
		frame_end && !write_latch && !busy
			|=> state_reg.phase == spiwp_pkg::PH_IDLE;
	endproperty
	a_no_latch_no_write: assert property (p_no_latch_no_write)
		else $error("write started without latch");

	property p_busy_during_write;
		reg_go |=> op_in_progress [*8];
	endproperty
	a_busy_during_write: assert property (p_busy_during_write)
		else $error("busy not shown during write");

	property p_done_clears_latch;
		write_done && !unlock_go |=> !write_latch && !op_in_progress
			|| embedded_busy || status_reg_one[5] || status_reg_one[6];
	endproperty
	a_done_clears_latch: assert property (p_done_clears_latch)
		else $error("latch not cleared at write end");

	property p_bank_load;
		bank_go && state_reg.bit_cnt == `SPIWP_LEN_ONE_BYTE
			|=> bank_addr_reg == $past(state_reg.data[1:0]);
	endproperty
	a_bank_load: assert property (p_bank_load)
		else $error("bank register load wrong");

	property p_write_length;
		reg_go |-> len_ok && !state_reg.bank_armed;
	endproperty
	a_write_length: assert property (p_write_length)
		else $error("write started with bad length");

	c_reg_write: cover property (reg_go ##[1:1000] write_done);
	c_locked: cover property (frame_end && hw_locked && len_ok);
	c_bank: cover property (bank_go);
	c_clear_busy: cover property (clear_go && busy);

endmodule // spiwp_ctrl

`default_nettype wire

//--- verification/spiwp_host.sv
// Purpose: host SPI controller model, mode 0 frames
// Assumes: bench calls send only between frames
// Notes:   sck idles low; si shows inverse of last bit when released
`timescale 1ns/1ps
`default_nettype none

module spiwp_host (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sck,
	output logic      si
);
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// msb first; chip select rises right after the last bit
	task automatic send(input logic [23:0] v, input int n);
		repeat (2) @(negedge clk);
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si = v[i];
			repeat (2) @(negedge clk);
			sck = 1'b1;
			repeat (2) @(negedge clk);
			sck = 1'b0;
		end
		repeat (2) @(negedge clk);
		cs_n = 1'b1;
		si   = ~si;
		repeat (3) @(negedge clk);
	endtask
endmodule // spiwp_host

`default_nettype wire

//--- verification/tb.sv
// Purpose: self-checking bench of the write-protect command logic
// Assumes: short self-timed write so the run stays brief
// Notes:   random register data from a fixed seed
`include "spiwp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int WC = 12;
	logic       clk, rstn, write_protect_n, embedded_busy;
	logic       erase_fail_set, program_fail_set, cs_n, sck, si;
	logic [7:0] status_reg_one, config_reg, d, c, sr_exp, cfg_exp;
	logic [1:0] bank_addr_reg;
	logic       write_latch, op_in_progress, hw_protected;
	logic       array_write_allow;
	int         n_fail = 0;
	int         compares = 0;
	int         cyc = 0;

	spiwp_host h (.clk, .cs_n, .sck, .si);
	spiwp_ctrl #(.WRITE_CYCLES(WC)) dut (.clk, .rstn, .cs_n, .sck, .si,
		.write_protect_n, .embedded_busy, .erase_fail_set,
		.program_fail_set, .status_reg_one, .config_reg, .bank_addr_reg,
		.write_latch, .op_in_progress, .hw_protected, .array_write_allow);

	task automatic chk8(input logic [7:0] g, input logic [7:0] e,
		input string m);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// status after an accepted write: lock and level taken, rest clear
	function automatic logic [7:0] exp_status(input logic [7:0] s);
		exp_status = {s[7], 2'b00, s[4:2], 2'b00};
	endfunction

	task automatic chk1(input logic g, input logic e, input string m);
		chk8({7'h00, g}, {7'h00, e}, m);
	endtask

	task automatic summarize();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// unlock, then register write of n bits; ok says it must be taken
	task automatic wr(input logic [7:0] s, input logic [7:0] cf,
		input int n, input logic ok);
		h.send(24'(`SPIWP_OP_WRITE_UNLOCK), 8);
		chk1(write_latch, 1'b1, "unlock");
		chk1(array_write_allow, 1'b1, "latch gate");
		h.send({`SPIWP_OP_REG_WRITE, s, cf} >> (24 - n), n);
		chk1(op_in_progress, ok, "write start");
		repeat (16) @(negedge clk);
		if (ok)
			sr_exp = exp_status(s);
		if (ok && n == 24)
			cfg_exp = cf;
		chk8(status_reg_one, sr_exp | {6'h00, !ok, 1'b0}, "status");
		chk8(config_reg, cfg_exp, "config");
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		rstn = 1'b0;
		write_protect_n = 1'b1;
		embedded_busy = 1'b0;
		erase_fail_set = 1'b0;
		program_fail_set = 1'b0;
		sr_exp = 8'h00;
		cfg_exp = 8'h00;
		void'($urandom(11));
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		chk8(status_reg_one, 8'h00, "status reset");
		chk8(config_reg, 8'h00, "config reset");
		h.send(24'({`SPIWP_OP_WRITE_UNLOCK, 8'h00}), 16);
		chk1(write_latch, 1'b0, "long unlock");
		h.send(24'({`SPIWP_OP_REG_WRITE, 8'h1C}), 16);
		chk1(op_in_progress, 1'b0, "write without latch");
		$display("test refusals done");
		for (int k = 0; k < 6; k++) begin
			d = 8'($urandom) & 8'h7F;
			c = 8'($urandom) & 8'hFD;
			wr(d, c, k[0] ? 24 : 16, 1'b1);
		end
		$display("test random writes done");
		wr(8'h88, 8'h00, 16, 1'b1);
		write_protect_n = 1'b0;
		@(negedge clk);
		chk1(hw_protected, 1'b1, "pin after lock");
		wr(8'h00, 8'hFF, 24, 1'b0);
		write_protect_n = 1'b1;
		wr(8'h00, 8'h00, 16, 1'b1);
		write_protect_n = 1'b0;
		wr(8'h84, 8'h00, 16, 1'b1);
		chk1(hw_protected, 1'b1, "lock after pin");
		write_protect_n = 1'b1;
		wr(8'h00, 8'h00, 16, 1'b1);
		$display("test protection done");
		h.send(24'(`SPIWP_OP_WRITE_UNLOCK), 8);
		embedded_busy = 1'b1;
		h.send(24'(`SPIWP_OP_WRITE_LOCK), 8);
		chk1(write_latch, 1'b1, "lock while busy");
		embedded_busy = 1'b0;
		h.send(24'({`SPIWP_OP_WRITE_LOCK, 8'h00}), 16);
		chk1(write_latch, 1'b1, "long lock");
		h.send(24'(`SPIWP_OP_WRITE_LOCK), 8);
		chk1(write_latch, 1'b0, "lock");
		$display("test latch commands done");
		h.send(24'(`SPIWP_OP_WRITE_UNLOCK), 8);
		erase_fail_set = 1'b1;
		program_fail_set = 1'b1;
		@(negedge clk);
		erase_fail_set = 1'b0;
		program_fail_set = 1'b0;
		@(negedge clk);
		chk8(status_reg_one, sr_exp | 8'h63, "flags set");
		h.send(24'(`SPIWP_OP_CLEAR_FLAGS), 8);
		chk8(status_reg_one, sr_exp | 8'h02, "flags cleared");
		h.send(24'(`SPIWP_OP_WRITE_LOCK), 8);
		$display("test flag clear done");
		d = 8'($urandom);
		// latch set so that a status write would be possible
		h.send(24'(`SPIWP_OP_WRITE_UNLOCK), 8);
		h.send(24'(`SPIWP_OP_BANK_ACCESS), 8);
		h.send({`SPIWP_OP_REG_WRITE, d, 8'hFF}, 24);
		chk8({6'h00, bank_addr_reg}, {6'h00, d[1:0]}, "bank");
		chk8(status_reg_one, sr_exp | 8'h02, "bank keeps status");
		h.send(24'(`SPIWP_OP_WRITE_LOCK), 8);
		$display("test bank load done");
		wr(8'h80, 8'h02, 24, 1'b1);
		write_protect_n = 1'b0;
		@(negedge clk);
		chk1(hw_protected, 1'b0, "quad mode");
		wr(8'h00, 8'h00, 16, 1'b0);
		wr(8'h00, 8'h00, 24, 1'b1);
		$display("test quad mode done");
		summarize();
	end
endmodule // tb

`default_nettype wire
